// ==== design/bdpr_consts.vh ====
`ifndef BDPR_CONSTS_VH
`define BDPR_CONSTS_VH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define BDPR_OFS_CTRL 12'h000
`define BDPR_OFS_STATUS 12'h004
`define BDPR_OFS_MASK 12'h008
`define BDPR_OFS_STATE 12'h00c

// ****************************************
// Control fields
// ****************************************
`define BDPR_CTRL_PRI_EN 0
`define BDPR_CTRL_SEC_EN 1
`define BDPR_CTRL_RST 2'h0

// ****************************************
// Status and mask fields
// ****************************************
`define BDPR_ST_PRI_MDPD 0
`define BDPR_ST_SEC_MDPD 1
`define BDPR_ST_PRI_PERR 2
`define BDPR_ST_SEC_PERR 3
`define BDPR_ST_W 4
`define BDPR_ST_RST 4'h0
`define BDPR_MASK_RST 4'h0

// ****************************************
// Transaction type codes
// ****************************************
`define BDPR_TYP_READ 2'h0
`define BDPR_TYP_PW 2'h1
`define BDPR_TYP_DW 2'h2

// ****************************************
// Sampling pipeline
// ****************************************
`define BDPR_SMP_W 6
`define BDPR_DLY_STAGES 5
`define BDPR_CLK_STAGES 3

`endif

// ==== design/bdpr_top.v ====
// How it works
// R01 - Primary master detect only on upstream transfers
// R02 - Primary master detect gated by primary enable
// R03 - Primary detect from pin or own check
// R04 - Secondary master detect only on downstream transfers
// R05 - Secondary master detect gated by secondary enable
// R06 - Secondary detect from pin or own check
// R07 - Primary pin only as write target/read initiator
// R08 - Primary pin asserted on primary parity error
// R09 - Downstream delayed write error relayed to primary
// R10 - Secondary pin only as write target/read initiator
// R11 - Secondary pin asserted on secondary parity error
// R12 - Upstream delayed write error relayed to secondary
// R13 - Primary pin low asserted, high idle
// R14 - Pins follow each bus clock's own edges
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`include "bdpr_consts.vh"

module bdpr_top (
  input wire mclk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire pri_bus_clk,
  input wire pri_data_phase,
  input wire pri_par_bad,
  input wire [1:0] pri_txn_type,
  input wire pri_txn_up,
  input wire primary_parity_err_n_i,
  output reg primary_parity_err_n_o,
  output reg primary_parity_err_n_oe,
  input wire sec_bus_clk,
  input wire sec_data_phase,
  input wire sec_par_bad,
  input wire [1:0] sec_txn_type,
  input wire sec_txn_up,
  input wire secondary_parity_err_n_i,
  output reg secondary_parity_err_n_o,
  output reg secondary_parity_err_n_oe,
  output reg irq
);

  localparam integer SW = `BDPR_SMP_W;
  localparam integer DW = `BDPR_SMP_W * `BDPR_DLY_STAGES;
  localparam integer CW = `BDPR_CLK_STAGES;
  // Quiet bus pattern, so no stale transfer type leaks out of reset
  localparam [SW-1:0] PIN_IDLE = {{(SW-1){1'b0}}, 1'b1};

  // ****************************************
  // Helpers
  // ****************************************
  // Bridge initiates on the primary bus for upstream, on secondary for downstream
  function initiator;
    input up;
    input is_pri;
    begin
      initiator = is_pri ? up : ~up;
    end
  endfunction

  // Delayed write decode
  function is_dw;
    input [1:0] typ;
    begin
      is_dw = (typ == `BDPR_TYP_DW);
    end
  endfunction

  // Rising edge of a sampled bus clock, read past the first stage
  function rise_of;
    input [CW-1:0] sh;
    begin
      rise_of = sh[1] & ~sh[2];
    end
  endfunction

  // Read initiator or write target may drive the pin
  function may_drive;
    input [1:0] typ;
    input up;
    input is_pri;
    begin
      if (initiator(up, is_pri)) begin
        may_drive = (typ == `BDPR_TYP_READ);
      end else begin
        may_drive = (typ != `BDPR_TYP_READ);
      end
    end
  endfunction

  // ****************************************
  // Bus clock and pin sampling
  // ****************************************
  reg [CW-1:0] pri_clk_reg;
  reg [CW-1:0] sec_clk_reg;
  reg [DW-1:0] pri_dly_reg;
  reg [DW-1:0] sec_dly_reg;
  wire [SW-1:0] pri_raw;
  wire [SW-1:0] sec_raw;
  wire [SW-1:0] pri_tap;
  wire [SW-1:0] sec_tap;
  wire pri_rise;
  wire sec_rise;

  assign pri_raw = {pri_data_phase, pri_par_bad, pri_txn_type, pri_txn_up,
                    primary_parity_err_n_i};
  assign sec_raw = {sec_data_phase, sec_par_bad, sec_txn_type, sec_txn_up,
                    secondary_parity_err_n_i};
  // Data path longer than clock path, so the tap shows values from before the edge
  assign pri_tap = pri_dly_reg[DW-1:DW-SW];
  assign sec_tap = sec_dly_reg[DW-1:DW-SW];
  assign pri_rise = rise_of(pri_clk_reg); // R14
  assign sec_rise = rise_of(sec_clk_reg); // R14

  always @(posedge mclk) begin
    if (!rst_n) begin
      pri_clk_reg <= {CW{1'b0}};
      pri_dly_reg <= {`BDPR_DLY_STAGES{PIN_IDLE}};
    end else begin
      pri_clk_reg <= {pri_clk_reg[CW-2:0], pri_bus_clk};
      pri_dly_reg <= {pri_dly_reg[DW-SW-1:0], pri_raw};
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      sec_clk_reg <= {CW{1'b0}};
      sec_dly_reg <= {`BDPR_DLY_STAGES{PIN_IDLE}};
    end else begin
      sec_clk_reg <= {sec_clk_reg[CW-2:0], sec_bus_clk};
      sec_dly_reg <= {sec_dly_reg[DW-SW-1:0], sec_raw};
    end
  end

  wire p_ph;
  wire p_bad;
  wire [1:0] p_typ;
  wire p_up;
  wire p_perr_n;
  wire s_ph;
  wire s_bad;
  wire [1:0] s_typ;
  wire s_up;
  wire s_perr_n;

  assign p_ph = pri_tap[5];
  assign p_bad = pri_tap[4];
  assign p_typ = pri_tap[3:2];
  assign p_up = pri_tap[1];
  assign p_perr_n = pri_tap[0];
  assign s_ph = sec_tap[5];
  assign s_bad = sec_tap[4];
  assign s_typ = sec_tap[3:2];
  assign s_up = sec_tap[1];
  assign s_perr_n = sec_tap[0];

  // ****************************************
  // Registers
  // ****************************************
  reg [1:0] ctrl_reg;
  reg [`BDPR_ST_W-1:0] status_reg;
  reg [`BDPR_ST_W-1:0] status_next;
  reg [`BDPR_ST_W-1:0] mask_reg;
  reg pend_pri_reg;
  reg pend_sec_reg;
  wire en_p;
  wire en_s;

  assign en_p = ctrl_reg[`BDPR_CTRL_PRI_EN];
  assign en_s = ctrl_reg[`BDPR_CTRL_SEC_EN];

  // ****************************************
  // Decisions at each bus edge
  // ****************************************
  wire p_mdpd;
  wire s_mdpd;
  wire p_drive;
  wire s_drive;
  wire p_dw_down;
  wire s_dw_up;
  wire relay_to_pri;
  wire relay_to_sec;

  assign p_mdpd = pri_rise & p_ph & initiator(p_up, 1'b1) // R01
                  & en_p // R02
                  & (~p_perr_n | p_bad); // R03
  assign s_mdpd = sec_rise & s_ph & initiator(s_up, 1'b0) // R04
                  & en_s // R05
                  & (~s_perr_n | s_bad); // R06

  assign p_dw_down = ~p_up & is_dw(p_typ);
  assign s_dw_up = s_up & is_dw(s_typ);

  // Target pin seen during a delayed write completion on the far bus
  assign relay_to_pri = sec_rise & s_ph & ~s_up & is_dw(s_typ)
                        & ~s_perr_n & en_s & en_p; // R09
  assign relay_to_sec = pri_rise & p_ph & p_up & is_dw(p_typ)
                        & ~p_perr_n & en_p & en_s; // R12

  assign p_drive = en_p & p_ph // R07
                   & ((may_drive(p_typ, p_up, 1'b1) & p_bad) // R08
                      | (pend_pri_reg & p_dw_down)); // R09
  assign s_drive = en_s & s_ph // R10
                   & ((may_drive(s_typ, s_up, 1'b0) & s_bad) // R11
                      | (pend_sec_reg & s_dw_up)); // R12

  // Relay waits for the initiator's retry; a new relay beats the consume
  always @(posedge mclk) begin
    if (!rst_n) begin
      pend_pri_reg <= 1'b0;
      pend_sec_reg <= 1'b0;
    end else begin
      if (relay_to_pri) begin
        pend_pri_reg <= 1'b1;
      end else if (pri_rise & p_drive & p_dw_down) begin
        pend_pri_reg <= 1'b0;
      end
      if (relay_to_sec) begin
        pend_sec_reg <= 1'b1;
      end else if (sec_rise & s_drive & s_dw_up) begin
        pend_sec_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Parity error pins
  // ****************************************
  // Low for one bus clock, then driven high one more clock before release
  always @(posedge mclk) begin
    if (!rst_n) begin
      primary_parity_err_n_o <= 1'b1;
      primary_parity_err_n_oe <= 1'b0;
    end else begin
      if (pri_rise) begin
        primary_parity_err_n_o <= ~p_drive; // R13
        primary_parity_err_n_oe <= p_drive | ~primary_parity_err_n_o; // R14
      end
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      secondary_parity_err_n_o <= 1'b1;
      secondary_parity_err_n_oe <= 1'b0;
    end else begin
      if (sec_rise) begin
        secondary_parity_err_n_o <= ~s_drive; // R11
        secondary_parity_err_n_oe <= s_drive | ~secondary_parity_err_n_o; // R14
      end
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  wire acc;
  wire done;
  wire hit;
  wire st_rd_clr;
  wire [`BDPR_ST_W-1:0] st_set;
  reg [31:0] rd_mux;

  assign acc = psel & penable & ~pready;
  assign done = psel & penable & pready;
  assign hit = (paddr == `BDPR_OFS_CTRL) | (paddr == `BDPR_OFS_STATUS)
               | (paddr == `BDPR_OFS_MASK) | (paddr == `BDPR_OFS_STATE);
  assign st_rd_clr = done & ~pwrite & (paddr == `BDPR_OFS_STATUS);
  assign st_set = {sec_rise & s_drive, pri_rise & p_drive, s_mdpd, p_mdpd};

  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `BDPR_OFS_CTRL: begin
        rd_mux = {30'h0000_0000, ctrl_reg};
      end
      `BDPR_OFS_STATUS: begin
        rd_mux = {28'h000_0000, status_reg};
      end
      `BDPR_OFS_MASK: begin
        rd_mux = {28'h000_0000, mask_reg};
      end
      `BDPR_OFS_STATE: begin
        rd_mux = {26'h000_0000, pend_sec_reg, pend_pri_reg,
                  secondary_parity_err_n_oe, secondary_parity_err_n_o,
                  primary_parity_err_n_oe, primary_parity_err_n_o};
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Events landing on the clearing read survive it
  always @* begin
    status_next = status_reg;
    if (st_rd_clr) begin
      status_next = {`BDPR_ST_W{1'b0}};
    end
    status_next = status_next | st_set;
  end

  // One wait state: prdata is loaded on the same edge that raises pready
  always @(posedge mclk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc;
      if (acc) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= ~hit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_reg <= `BDPR_CTRL_RST;
      mask_reg <= `BDPR_MASK_RST;
      status_reg <= `BDPR_ST_RST;
      irq <= 1'b0;
    end else begin
      if (done & pwrite & (paddr == `BDPR_OFS_CTRL)) begin
        ctrl_reg <= pwdata[1:0];
      end
      if (done & pwrite & (paddr == `BDPR_OFS_MASK)) begin
        mask_reg <= pwdata[`BDPR_ST_W-1:0];
      end
      status_reg <= status_next;
      irq <= |(status_next & mask_reg);
    end
  end

endmodule // bdpr_top

// ==== verif/bdpr_agent.sv ====
module bdpr_agent #(
  parameter realtime START = 0.0
) (
  output logic bus_clk,
  output logic data_phase,
  output logic par_bad,
  output logic [1:0] txn_type,
  output logic txn_up,
  output logic pin_n,
  input wire logic pin_o,
  input wire logic pin_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic agent_low = 1'b0;
  // ********
  // Bus agents on one side
  // ********
  initial begin
    {data_phase, par_bad, txn_type, txn_up} = 5'h0;
    bus_clk = 1'b0;
    #START;
    forever #62.5 bus_clk = ~bus_clk;
  end
  // Pull-up holds the pin high when nobody drives it
  assign pin_n = pin_oe ? pin_o : !agent_low;
  // Changes at falling edges keep setup and hold around the rising edge
  task automatic phase(input logic [1:0] t, input logic u, input logic b, input logic p);
    @(negedge bus_clk);
    data_phase = 1'b1;
    txn_type = t;
    txn_up = u;
    par_bad = b;
    agent_low = p;
    @(negedge bus_clk);
    data_phase = 1'b0;
    txn_type = ~t;
    txn_up = ~u;
    par_bad = ~b;
    agent_low = 1'b0;
  endtask
endmodule // bdpr_agent

// ==== verif/bdpr_props.sv ====
module bdpr_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic primary_parity_err_n_o,
  input wire logic primary_parity_err_n_oe,
  input wire logic secondary_parity_err_n_o,
  input wire logic secondary_parity_err_n_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********
  // Port relations
  // ********
  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  apb_err_a: assert property (pslverr |-> pready && psel && penable)
    else $error("stray pslverr");
  pri_idle_a: assert property (!primary_parity_err_n_oe |-> primary_parity_err_n_o)
    else $error("primary pin low but undriven");
  sec_idle_a: assert property (!secondary_parity_err_n_oe |-> secondary_parity_err_n_o)
    else $error("secondary pin low but undriven");
  // Low for one bus clock of 12 to 13 cycles, driven all along
  pri_low_a: assert property ($fell(primary_parity_err_n_o) |->
    primary_parity_err_n_oe throughout
    (!primary_parity_err_n_o [*8] ##[1:12] primary_parity_err_n_o))
    else $error("primary pin low width");
  sec_low_a: assert property ($fell(secondary_parity_err_n_o) |->
    secondary_parity_err_n_oe throughout
    (!secondary_parity_err_n_o [*8] ##[1:12] secondary_parity_err_n_o))
    else $error("secondary pin low width");
  pri_hold_a: assert property ($rose(primary_parity_err_n_o) |->
    primary_parity_err_n_oe [*8] ##[1:12] !primary_parity_err_n_oe)
    else $error("primary pin release");
  sec_hold_a: assert property ($rose(secondary_parity_err_n_o) |->
    secondary_parity_err_n_oe [*8] ##[1:12] !secondary_parity_err_n_oe)
    else $error("secondary pin release");
  cover property ($fell(primary_parity_err_n_o));
  cover property ($fell(secondary_parity_err_n_o));
  cover property (pslverr);
endmodule // bdpr_props

bind bdpr_top bdpr_props bdpr_props_i (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .primary_parity_err_n_o(primary_parity_err_n_o),
  .primary_parity_err_n_oe(primary_parity_err_n_oe),
  .secondary_parity_err_n_o(secondary_parity_err_n_o),
  .secondary_parity_err_n_oe(secondary_parity_err_n_oe));

// ==== verif/tb.sv ====
`include "bdpr_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pclk, pdp, pbad, pup, ppin, po, poe, sclk, sdp, sbad, sup, spin, so, soe;
  logic [1:0] ptyp, styp;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  // Bus, type, upstream, bad parity, pin low, control, expected status
  logic [11:0] rows [19] = '{12'h1b5, 12'h371, 12'h5b1, 12'h2b4, 12'h4b4, 12'h0b0, 12'h1a0,
    12'h195, 12'h8ba, 12'ha72, 12'hbb8, 12'h890, 12'h9b0, 12'hc62, 12'h430, 12'hc72, 12'h434,
    12'h571, 12'hd38};
  bdpr_top bdpr_top_i (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pri_bus_clk(pclk), .pri_data_phase(pdp), .pri_par_bad(pbad),
    .pri_txn_type(ptyp), .pri_txn_up(pup), .primary_parity_err_n_i(ppin),
    .primary_parity_err_n_o(po), .primary_parity_err_n_oe(poe), .sec_bus_clk(sclk),
    .sec_data_phase(sdp), .sec_par_bad(sbad), .sec_txn_type(styp), .sec_txn_up(sup),
    .secondary_parity_err_n_i(spin), .secondary_parity_err_n_o(so),
    .secondary_parity_err_n_oe(soe), .irq(irq));
  bdpr_agent bdpr_agent_i (.bus_clk(pclk), .data_phase(pdp), .par_bad(pbad), .txn_type(ptyp),
    .txn_up(pup), .pin_n(ppin), .pin_o(po), .pin_oe(poe));
  bdpr_agent #(.START(17.0)) bdpr_agent_2_i (.bus_clk(sclk), .data_phase(sdp), .par_bad(sbad),
    .txn_type(styp), .txn_up(sup), .pin_n(spin), .pin_o(so), .pin_oe(soe));
  // ********
  // Clock, timeout and bus tasks
  // ********
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ********
  // Main sequence
  // ********
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(`BDPR_OFS_CTRL, 32'h0);
    rdc(`BDPR_OFS_MASK, 32'h0);
    rdc(`BDPR_OFS_STATE, 32'h5);
    xfer(1'b1, `BDPR_OFS_MASK, 32'h3);
    rdc(`BDPR_OFS_MASK, 32'h3);
    rdc(12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("Test registers done");
    // Mask keeps only the master detect bits on the interrupt
    foreach (rows[i]) begin
      xfer(1'b1, `BDPR_OFS_CTRL, {30'h0, rows[i][5:4]});
      if (rows[i][11]) bdpr_agent_2_i.phase(rows[i][10:9], rows[i][8], rows[i][7], rows[i][6]);
      else bdpr_agent_i.phase(rows[i][10:9], rows[i][8], rows[i][7], rows[i][6]);
      repeat (40) @(posedge mclk);
      chk({31'h0, irq}, {31'h0, |(rows[i][3:0] & 4'h3)});
      rdc(`BDPR_OFS_STATUS, {28'h0, rows[i][3:0]});
    end
    rdc(`BDPR_OFS_STATUS, 32'h0);
    $display("Test parity table done");
    conclude();
  end
endmodule // tb
